//--- hw/dpram_ctl_defines.svh
`ifndef DPRAM_CTL_DEFINES_SVH
`define DPRAM_CTL_DEFINES_SVH
// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define REG_CTRL          8'h00
`define REG_ADDR          8'h04
`define REG_WDATA         8'h08
`define REG_RDATA         8'h0C
`define REG_STATUS        8'h10
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CTRL_GO           0
`define CTRL_WRITE        1
`define CTRL_TOKEN        2
`define CTRL_UPPER        3
`define CTRL_LOWER        4
`define STAT_ACTIVE       0
`define STAT_DONE         1
`define STAT_BUSY_SEEN    2
`define STAT_MBOX         3
`define STAT_BUSY_NOW     4
// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CTRL_RST          5'h18
`define ADDR_RST          32'h00000000
`define WDATA_RST         32'h00000000
// ----------------------------------------------------------------------------
// timing, ns figures and derived cycle counts at the clock rate
// ----------------------------------------------------------------------------
`define CLK_MHZ           20
`define FLAG_MATCH_NS     20
`define FLAG_SELECT_NS    20
`define ACCESS_NS         20
`define FLOWTHROUGH_NS    30
`define WR_PULSE_NS       15
`define NS_TO_CYC(ns)     ((((ns) * `CLK_MHZ) + 999) / 1000)
`define SYNC_CYC          2
`define SETTLE_CYC        (`NS_TO_CYC(`FLAG_MATCH_NS) + `NS_TO_CYC(`FLAG_SELECT_NS) + `SYNC_CYC)
`define READ_CYC          (`NS_TO_CYC(`ACCESS_NS) + `NS_TO_CYC(`FLOWTHROUGH_NS) + `SYNC_CYC)
`define WR_CYC            `NS_TO_CYC(`WR_PULSE_NS)
`endif

//--- hw/dpram_ctl_pkg.sv
package dpram_ctl_pkg;
  // --------------------------------------------------------------------------
  // port access sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SEL,
    ST_PULSE,
    ST_READ,
    ST_END
  } seq_state_t;
endpackage : dpram_ctl_pkg

//--- hw/dpram_port_ctl.sv
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "dpram_ctl_defines.svh"
module dpram_port_ctl
  import dpram_ctl_pkg::*;
#(
  parameter int AW = 16,                          // port address width
  parameter int DW = 18                           // port data width
) (
  input  wire logic          i_clk,               // system clock, 20 MHz
  input  wire logic          i_rstn,              // async reset, active low
  input  wire logic          i_psel,              // apb select
  input  wire logic          i_penable,           // apb enable
  input  wire logic          i_pwrite,            // apb direction
  input  wire logic [7:0]    i_paddr,             // apb byte address
  input  wire logic [31:0]   i_pwdata,            // apb write data
  output logic      [31:0]   o_prdata,            // apb read data
  output logic               o_pready,            // apb ready
  output logic               o_pslverr,           // apb error, unmapped
  output logic [AW-1:0]      o_addr,              // port address pins
  output logic [DW-1:0]      o_dq,                // port data out
  output logic               o_dq_oen,            // data drive enable, low drives
  input  wire logic [DW-1:0] i_dq,                // port data in
  output logic               o_array_select_n,    // array chip select
  output logic               o_token_select_n,    // token latch select
  output logic               o_rw_n,              // read high, write low
  output logic               o_oe_n,              // device output enable
  output logic               o_upper_lane_select_n, // upper byte lane
  output logic               o_lower_lane_select_n, // lower byte lane
  input  wire logic          i_busy_n,            // contention flag from device
  input  wire logic          i_mbox_int_n         // mailbox interrupt from device
);
  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  seq_state_t     state_r;
  logic [7:0]     cnt_r;
  logic [4:0]     ctrl_r;
  logic [AW-1:0]  addr_r;
  logic [DW-1:0]  wdata_r;
  logic [DW-1:0]  rdata_r;
  logic           done_r;
  logic           busy_seen_r;
  logic [DW-1:0]  dq_m_r;
  logic [DW-1:0]  dq_s_r;
  logic           busy_m_r;
  logic           busy_s_r;
  logic           int_m_r;
  logic           int_s_r;
  logic           go;
  logic           wr_go;
  logic           is_wr;
  logic           is_tok;
  logic           fin;
  logic           apb_wr;
  logic           apb_rd;
  logic           apb_acc;
  logic [7:0]     rd_wait_r;

  // count comparison against a derived cycle count
  function automatic logic cnt_hit(input logic [7:0] c, input int n);
    cnt_hit = (c == 8'(n - 1));
  endfunction : cnt_hit

  // --------------------------------------------------------------------------
  // pin input synchronisers
  // --------------------------------------------------------------------------
  // two stages before any logic looks at device pins
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dq_m_r   <= '0;
      dq_s_r   <= '0;
      busy_m_r <= 1'b1;
      busy_s_r <= 1'b1;
      int_m_r  <= 1'b1;
      int_s_r  <= 1'b1;
    end else begin
      dq_m_r   <= i_dq;
      dq_s_r   <= dq_m_r;
      busy_m_r <= i_busy_n;
      busy_s_r <= busy_m_r;
      int_m_r  <= i_mbox_int_n;
      int_s_r  <= int_m_r;
    end
  end

  // --------------------------------------------------------------------------
  // apb slave
  // --------------------------------------------------------------------------
  // reads are decoded in the first access cycle, writes land when ready is seen
  assign apb_acc = i_psel && i_penable && !o_pready;
  assign apb_wr  = i_psel && i_penable && i_pwrite && o_pready;
  assign apb_rd  = apb_acc && !i_pwrite;
  assign is_wr  = ctrl_r[`CTRL_WRITE];
  assign is_tok = ctrl_r[`CTRL_TOKEN];
  assign go     = apb_wr && (i_paddr == `REG_CTRL) && i_pwdata[`CTRL_GO]
                  && (state_r == ST_IDLE);
  assign fin    = (state_r == ST_END);

  // ready one cycle into the access phase, read data and error with it
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pready  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && i_penable && !o_pready;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
      if (apb_acc) begin
        unique case (i_paddr)
          `REG_CTRL:   o_prdata <= {27'h0000000, ctrl_r[4:1], 1'b0};
          `REG_ADDR:   o_prdata <= 32'(addr_r);
          `REG_WDATA:  o_prdata <= 32'(wdata_r);
          `REG_RDATA:  o_prdata <= 32'(rdata_r);
          `REG_STATUS: o_prdata <= {27'h0000000, !busy_s_r, !int_s_r,
                                    busy_seen_r, done_r, state_r != ST_IDLE};
          default:     o_pslverr <= 1'b1;
        endcase
        if (!apb_rd)
          o_prdata <= '0;
      end
    end
  end

  // command registers, frozen while a port cycle runs
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r  <= `CTRL_RST;
      addr_r  <= AW'(`ADDR_RST);
      wdata_r <= DW'(`WDATA_RST);
    end else if (apb_wr && state_r == ST_IDLE) begin
      if (i_paddr == `REG_CTRL)
        ctrl_r <= {i_pwdata[4:1], 1'b0};
      if (i_paddr == `REG_ADDR)
        addr_r <= i_pwdata[AW-1:0];
      if (i_paddr == `REG_WDATA)
        wdata_r <= i_pwdata[DW-1:0];
    end
  end

  // sticky status, a new event wins over a write-one clear
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      done_r      <= 1'b0;
      busy_seen_r <= 1'b0;
    end else begin
      if (apb_wr && i_paddr == `REG_STATUS && i_pwdata[`STAT_DONE])
        done_r <= 1'b0;
      if (apb_wr && i_paddr == `REG_STATUS && i_pwdata[`STAT_BUSY_SEEN])
        busy_seen_r <= 1'b0;
      if (fin)
        done_r <= 1'b1;
      if (state_r == ST_SEL && !busy_s_r)
        busy_seen_r <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // port cycle sequencer
  // --------------------------------------------------------------------------
  // write may start only once the settle time passed and, for array writes, the flag is inactive
  assign wr_go = cnt_hit(cnt_r, `SETTLE_CYC) && (busy_s_r || is_tok);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      unique case (state_r)
        ST_IDLE: begin
          cnt_r <= '0;
          if (go)
            state_r <= ST_ADDR;
        end
        ST_ADDR: begin
          cnt_r   <= '0;
          state_r <= ST_SEL;
        end
        ST_SEL: begin
          if (cnt_hit(cnt_r, `SETTLE_CYC))
            cnt_r <= cnt_r;
          if (!is_wr) begin
            cnt_r   <= '0;
            state_r <= ST_READ;
          end else if (wr_go) begin
            cnt_r   <= '0;
            state_r <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (cnt_hit(cnt_r, `WR_CYC))
            state_r <= ST_END;
        end
        ST_READ: begin
          if (cnt_hit(cnt_r, `READ_CYC))
            state_r <= ST_END;
        end
        ST_END: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // address and write data change only in idle, strobe high there
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_addr   <= '0;
      o_dq     <= '0;
      o_dq_oen <= 1'b1;
    end else begin
      if (go) begin
        o_addr <= addr_r;
        o_dq   <= wdata_r;
      end
      if (state_r == ST_ADDR)
        o_dq_oen <= !is_wr;
      if (fin)
        o_dq_oen <= 1'b1;
    end
  end

  // selects fall before the strobe so device outputs stay off on writes
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_array_select_n      <= 1'b1;
      o_token_select_n      <= 1'b1;
      o_upper_lane_select_n <= 1'b1;
      o_lower_lane_select_n <= 1'b1;
      o_oe_n                <= 1'b1;
      o_rw_n                <= 1'b1;
    end else begin
      if (state_r == ST_ADDR) begin
        o_array_select_n      <= is_tok;
        o_token_select_n      <= !is_tok;
        o_upper_lane_select_n <= is_tok || !ctrl_r[`CTRL_UPPER];
        o_lower_lane_select_n <= is_tok || !ctrl_r[`CTRL_LOWER];
        o_oe_n                <= is_wr;
      end
      if (state_r == ST_SEL && is_wr && wr_go)
        o_rw_n <= 1'b0;
      if (state_r == ST_PULSE && cnt_hit(cnt_r, `WR_CYC))
        o_rw_n <= 1'b1;
      if (fin) begin
        o_array_select_n      <= 1'b1;
        o_token_select_n      <= 1'b1;
        o_upper_lane_select_n <= 1'b1;
        o_lower_lane_select_n <= 1'b1;
        o_oe_n                <= 1'b1;
      end
    end
  end

  // read data taken after access and flowthrough time plus sync delay
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_r <= '0;
    end else if (state_r == ST_READ && cnt_hit(cnt_r, `READ_CYC)) begin
      rdata_r <= dq_s_r;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  // helper: cycles the device output enable has been low
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      rd_wait_r <= '0;
    else if (o_oe_n)
      rd_wait_r <= '0;
    else if (rd_wait_r != 8'hFF)
      rd_wait_r <= rd_wait_r + 8'h01;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_ADDR_RW_HIGH: assert property ($changed(o_addr) |-> o_rw_n && $past(o_rw_n))
    else $error("address changed with write strobe low");
  AST_TOKEN_NOT_ARRAY: assert property (!o_token_select_n |-> o_array_select_n)
    else $error("token select with array select low");
  AST_READ_ENABLES: assert property (state_r == ST_READ |-> !o_oe_n && o_rw_n
                                     && (!o_array_select_n || !o_token_select_n))
    else $error("read without select and output enable");
  AST_FLOW_WAIT: assert property (state_r == ST_READ && cnt_hit(cnt_r, `READ_CYC)
                                  |-> rd_wait_r >= 8'(`READ_CYC))
    else $error("read data taken before flowthrough time");
  AST_BUSY_SETTLED: assert property ($fell(o_rw_n) && !o_array_select_n
                                     |-> $past(busy_s_r) && $past(!o_array_select_n, 3))
    else $error("array write started during contention or before settle");
  AST_SEL_BEFORE_RW: assert property ($fell(o_rw_n)
                                      |-> $past(!o_array_select_n || !o_token_select_n))
    else $error("strobe fell before a select");
  AST_WRITE_DRIVES: assert property (!o_rw_n |-> !o_dq_oen && o_oe_n
                                     && $past(!o_dq_oen))
    else $error("write strobe low without data driven");
  AST_PULSE_LEN: assert property ($fell(o_rw_n) |-> !o_rw_n ##1 o_rw_n ##1 state_r == ST_IDLE)
    else $error("write pulse length wrong");
  AST_APB_READY: assert property (i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
    else $error("apb ready not a single cycle");
endmodule : dpram_port_ctl

//--- tb/dpram_dev_model.sv
`timescale 1ns/1ps
module dpram_dev_model #(
  parameter int AW = 16,                         // address width
  parameter int DW = 18                          // data width
) (
  input  wire logic          i_rstn,                // power-on start, active low
  input  wire logic [AW-1:0] i_addr,                // address pins
  input  wire logic [DW-1:0] i_dq,                  // data from controller
  input  wire logic          i_dq_oen,              // controller drive, low drives
  output logic      [DW-1:0] o_dq,                  // data to controller
  input  wire logic          i_array_select_n,      // array select
  input  wire logic          i_token_select_n,      // token select
  input  wire logic          i_rw_n,                // read high, write low
  input  wire logic          i_oe_n,                // output enable
  input  wire logic          i_upper_lane_select_n, // upper lane
  input  wire logic          i_lower_lane_select_n, // lower lane
  input  wire logic          i_busy_n,              // contention flag input, slave
  input  wire logic          i_peer_wr,             // peer writes our mailbox
  input  wire logic          i_peer_ack,            // peer reads its own mailbox
  output logic               o_int_n,               // our mailbox interrupt
  output logic               o_peer_int_n           // peer mailbox interrupt
);
  localparam logic [AW-1:0] MB_PEER = '1;             // top word
  localparam logic [AW-1:0] MB_OWN  = MB_PEER - 1'b1; // next word
  logic [DW-1:0] mem [logic [AW-1:0]];
  logic [1:0]    owner [8];                      // 0 free, 1 ours, 2 peer
  logic          pend, pend_tok, rd_en, rd_en_d, clr;
  logic [AW-1:0] wa;
  logic [DW-1:0] wd, wm, rd_val, last;
  // --------------------------------------------------------------------------
  // write capture and commit
  // --------------------------------------------------------------------------
  // hold what was written while strobe and token select, or strobe, array select and a lane, overlap
  always @* begin
    if (!i_rw_n && (!i_token_select_n || (!i_array_select_n &&
        (!i_upper_lane_select_n || !i_lower_lane_select_n)))) begin
      pend = 1'b1;
      pend_tok = !i_token_select_n;
      wa = i_addr;
      wd = i_dq_oen ? ~i_dq : i_dq;              // undriven data lands corrupted
      wm = {{(DW-9){!i_upper_lane_select_n}}, {9{!i_lower_lane_select_n}}};
    end
  end
  // the write ends at whichever of strobe or select rises first
  always @(posedge i_rw_n or posedge i_array_select_n or posedge i_token_select_n
           or posedge i_peer_ack or negedge i_rstn) begin
    if (!i_rstn) begin
      foreach (owner[k]) owner[k] = 2'd0;
      o_peer_int_n = 1'b1;
      pend = 1'b0;
    end else if (i_peer_ack) begin
      o_peer_int_n = 1'b1;
    end else if (pend) begin
      pend = 1'b0;
      if (pend_tok) begin
        if (!wd[0] && owner[wa[2:0]] == 2'd0) owner[wa[2:0]] = 2'd1;
        else if (wd[0] && owner[wa[2:0]] == 2'd1) owner[wa[2:0]] = 2'd0;
      end else if (i_busy_n) begin
        mem[wa] = ((mem.exists(wa) ? mem[wa] : '0) & ~wm) | (wd & wm);
        if (wa == MB_PEER) o_peer_int_n = 1'b0;
      end
    end
  end
  // --------------------------------------------------------------------------
  // our mailbox interrupt
  // --------------------------------------------------------------------------
  assign clr = !i_array_select_n && !i_oe_n && i_rw_n && i_addr == MB_OWN && i_busy_n;
  always @(posedge i_peer_wr or posedge clr or negedge i_rstn) begin
    if (!i_rstn || clr) o_int_n = 1'b1;
    else o_int_n = 1'b0;
  end
  // --------------------------------------------------------------------------
  // read path, late data and a garbage pattern when not driving
  // --------------------------------------------------------------------------
  assign rd_en = !i_oe_n && i_rw_n && (!i_array_select_n || !i_token_select_n);
  assign #20 rd_en_d = rd_en;                    // access delay
  always @* begin
    if (!i_token_select_n) rd_val = {DW{owner[i_addr[2:0]] != 2'd1}};
    else rd_val = mem.exists(i_addr) ? mem[i_addr] : '0;
    if (rd_en && rd_en_d) begin
      last = rd_val;
      o_dq = rd_val;
    end else o_dq = ~last;
  end
endmodule : dpram_dev_model

//--- tb/tb.sv
`timescale 1ns/1ps
`include "dpram_ctl_defines.svh"
module tb;
  logic        i_clk, i_rstn, psel, penable, pwrite, pready, err, busy_n, peer_wr, peer_ack;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] addr, addr_q, a;
  logic [17:0] dq_c, dq_d, v;
  logic        dq_oen, asel_n, tsel_n, rw_n, oe_n, ub_n, lb_n, int_n, peer_int_n, slverr;
  int          bad_count, checks_done, rs;
  dpram_port_ctl u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(slverr), .o_addr(addr), .o_dq(dq_c), .o_dq_oen(dq_oen),
    .i_dq(dq_d), .o_array_select_n(asel_n), .o_token_select_n(tsel_n), .o_rw_n(rw_n),
    .o_oe_n(oe_n), .o_upper_lane_select_n(ub_n), .o_lower_lane_select_n(lb_n),
    .i_busy_n(busy_n), .i_mbox_int_n(int_n));
  dpram_dev_model u_dev (.i_rstn(i_rstn), .i_addr(addr), .i_dq(dq_c), .i_dq_oen(dq_oen),
    .o_dq(dq_d), .i_array_select_n(asel_n), .i_token_select_n(tsel_n), .i_rw_n(rw_n),
    .i_oe_n(oe_n), .i_upper_lane_select_n(ub_n), .i_lower_lane_select_n(lb_n),
    .i_busy_n(busy_n), .i_peer_wr(peer_wr), .i_peer_ack(peer_ack), .o_int_n(int_n),
    .o_peer_int_n(peer_int_n));
  // 20 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, d};
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = slverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // fields first, then the same word with go
  task automatic go(input logic [4:0] f);
    apb(1'b1, `REG_CTRL, {27'h0, f});
    apb(1'b1, `REG_CTRL, {27'h0, f | 5'h01});
  endtask : go
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      apb(1'b0, `REG_STATUS, 32'h0);
      n++;
    end while (rd[`STAT_DONE] !== 1'b1 && n < 60);
    check("done seen", {31'h0, rd[`STAT_DONE]}, 32'h1);
    apb(1'b1, `REG_STATUS, 32'h6);             // clear done and busy_seen
  endtask : wait_done
  // fields {lower, upper, token, write, go}; leaves read data in rd
  task automatic acc(input logic [4:0] f, input logic [15:0] ad, input logic [17:0] d);
    apb(1'b1, `REG_ADDR, {16'h0, ad});
    apb(1'b1, `REG_WDATA, {14'h0, d});
    go(f);
    wait_done;
    apb(1'b0, `REG_RDATA, 32'h0);
  endtask : acc
  function automatic logic [31:0] merge(input logic [17:0] o, n, input logic [1:0] ln);
    return {14'h0, ln[0] ? n[17:9] : o[17:9], ln[1] ? n[8:0] : o[8:0]};
  endfunction : merge
  // strobe low only under a select, address still while it is low
  always @(posedge i_clk) begin
    if (i_rstn && rw_n === 1'b0) begin
      check("strobe select", {31'h0, asel_n & tsel_n}, 32'h0);
      check("addr steady", {16'h0, addr}, {16'h0, addr_q});
    end
    addr_q <= addr;
  end
  initial begin
    repeat (30000) @(posedge i_clk);
    bad_count++;
    summarize();
  end
  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    {i_rstn, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {busy_n, peer_wr, peer_ack, addr_q, bad_count, checks_done} = {3'b100, 16'h0, 64'h0};
    #1 i_rstn = 1'b0;                          // a real falling edge for every reset branch
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'b1;
    rs = $urandom(95997);
    check("pins idle", {25'h0, asel_n, tsel_n, rw_n, oe_n, ub_n, lb_n, dq_oen}, 32'h7F);
    apb(1'b0, `REG_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h18);
    apb(1'b0, `REG_STATUS, 32'h0);
    check("status reset", rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      a = 16'($urandom_range(16'hFFFD));
      v = 18'($urandom);
      acc(5'h1A, a, v);
      acc(5'h18, a, 18'h0);
      check("array data", rd, {14'h0, v});
    end
    acc(5'h12, a, 18'h0);                      // lower lane only
    acc(5'h18, a, 18'h0);
    check("lane merge", rd, merge(v, 18'h0, 2'b10));
    acc(5'h0A, a, 18'h3FFFF);                  // upper lane only
    acc(5'h18, a, 18'h0);
    check("upper merge", rd, merge(18'h0, 18'h3FFFF, 2'b01));
    // write to peer mailbox held back by contention
    busy_n <= 1'b0;
    a = 16'hFFFF;
    v = 18'($urandom);
    apb(1'b1, `REG_ADDR, {16'h0, a});
    apb(1'b1, `REG_WDATA, {14'h0, v});
    go(5'h1A);
    repeat (20) @(posedge i_clk);
    apb(1'b1, `REG_ADDR, 32'h0);               // refused while active
    apb(1'b0, `REG_STATUS, 32'h0);
    check("busy holds write", {28'h0, rd[4], rd[1:0], peer_int_n}, 32'hB);
    busy_n <= 1'b1;
    wait_done;
    apb(1'b0, `REG_ADDR, 32'h0);
    check("addr kept", rd, {16'h0, a});
    check("peer irq", {31'h0, peer_int_n}, 32'h0);
    acc(5'h18, a, 18'h0);
    check("mailbox data", rd, {14'h0, v});
    check("peer irq kept", {31'h0, peer_int_n}, 32'h0);
    @(posedge i_clk) {peer_wr, peer_ack} <= 2'b11;
    @(posedge i_clk) {peer_wr, peer_ack} <= 2'b00;
    repeat (4) @(posedge i_clk);
    apb(1'b0, `REG_STATUS, 32'h0);
    check("own irq set", {28'h0, rd[3:0]}, 32'h8);
    acc(5'h18, 16'hFFFF, 18'h0);
    apb(1'b0, `REG_STATUS, 32'h0);
    check("peer box read", {31'h0, rd[3]}, 32'h1);
    busy_n <= 1'b0;
    acc(5'h18, 16'hFFFE, 18'h0);
    apb(1'b0, `REG_STATUS, 32'h0);
    check("busy keeps irq", {30'h0, rd[4:3]}, 32'h3);
    busy_n <= 1'b1;
    acc(5'h18, 16'hFFFE, 18'h0);
    apb(1'b0, `REG_STATUS, 32'h0);
    check("own irq clear", {31'h0, rd[3]}, 32'h0);
    // tokens: free, claim, release through varying high address bits
    for (int k = 0; k < 8; k++) begin
      a = {13'($urandom), 3'(k)};
      acc(5'h04, a, 18'h0);
      check("token free", {31'h0, rd[0]}, 32'h1);
      acc(5'h06, a ^ 16'hFFF8, 18'h3FFFE);
      acc(5'h04, a, 18'h0);
      check("token claimed", {31'h0, rd[0]}, 32'h0);
      acc(5'h06, a, 18'h00001);
      acc(5'h04, a, 18'h0);
      check("token released", {31'h0, rd[0]}, 32'h1);
    end
    u_dev.owner[5] = 2'd2;                     // peer holds token five
    acc(5'h06, 16'h0005, 18'h0);
    acc(5'h06, 16'h0005, 18'h1);
    acc(5'h04, 16'h0005, 18'h0);
    check("peer token", {31'h0, rd[0]}, 32'h1);
    summarize();
  end
endmodule : tb
